// [hw/clc_defines.svh]
// Register map, field positions and reset values of the logic cell block.
`ifndef CLC_DEFINES_SVH
`define CLC_DEFINES_SVH

// Word address bit that selects the shared registers instead of a cell.
// It is byte address bit 10, so the shared window starts at byte 0x400.
`define CLC_GLOBAL_BIT 8
// Word index of each register inside one cell window.
`define CLC_REG_CON    4'h0
`define CLC_REG_POL    4'h1
`define CLC_REG_DSEL0  4'h2
`define CLC_REG_DSEL3  4'h5
`define CLC_REG_GSEL0  4'h6
`define CLC_REG_GSEL3  4'h9
// Word index of each shared register.
`define CLC_REG_MIRROR 4'h0
`define CLC_REG_PSEL0  4'h1
`define CLC_REG_PSEL3  4'h4
`define CLC_REG_STATUS 4'h5
`define CLC_REG_MASK   4'h6

// Field positions of the control and polarity registers.
`define CLC_CON_EN     7
`define CLC_CON_OUT    5
`define CLC_CON_INTP   4
`define CLC_CON_INTN   3
`define CLC_POL_OUT    7

// Reset values.
`define CLC_CON_RST    8'h00
`define CLC_GSEL_RST   8'h00
`define CLC_DSEL_RST   6'h00
`define CLC_MIRROR_RST 4'h0

`endif

// [hw/clc_pkg.sv]
// Types shared by the logic cell files.
package clc_pkg;

	// Cell function codes.
	typedef enum logic [2:0] {
		MODE_AND_OR = 3'h0,
		MODE_OR_XOR = 3'h1,
		MODE_AND4   = 3'h2,
		MODE_SR     = 3'h3,
		MODE_DFF1   = 3'h4,
		MODE_DFF2   = 3'h5,
		MODE_JK     = 3'h6,
		MODE_LATCH  = 3'h7
	} mode_t;

	// Software settings of one cell.
	typedef struct packed {
		logic             cell_enable;
		logic             rise_irq_enable;
		logic             fall_irq_enable;
		mode_t            cell_function_select;
		logic             output_invert;
		logic [3:0]       gate_invert;
		logic [3:0][5:0]  dsel;
		logic [3:0][7:0]  gsel;
	} cell_cfg_t;

	// OR of the true and inverted forms picked by a gate select byte.
	function automatic logic gate_fn(input logic [3:0] d, input logic [7:0] sel);
		logic acc;
		acc = 1'b0;
		for (int k = 0; k < 4; k++) begin
			acc = acc | (sel[2*k+1] & d[k]) | (sel[2*k] & ~d[k]);
		end
		return acc;
	endfunction

endpackage

// [hw/clc_gate.sv]
// One gate: selected input forms ORed, then the gate polarity.
`timescale 1ns/1ns
`default_nettype none

module clc_gate (
	// Data inputs of the cell and the select byte.
	input  wire logic       [3:0] d,
	input  wire logic       [7:0] sel,
	input  wire logic             inv,
	// Gate result after polarity.
	output logic                  g
);

	////////////////////////////////////////////////////////////////////////
	// An empty select gives zero before polarity, so a gate is a constant
	// that software can still flip with its polarity bit.
	always_comb begin
		g = clc_pkg::gate_fn(d, sel) ^ inv;
	end

endmodule
`default_nettype wire

// [hw/clc_mode.sv]
// Function logic of one cell, combinational and sequential modes.
`timescale 1ns/1ns
`default_nettype none

module clc_mode (
	// Clock and reset.
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Gate results and selected function.
	input  wire logic       [3:0] g,
	input  wire clc_pkg::mode_t   mode,
	// Cell result before output polarity.
	output logic                  res
);

	// Stored bit and the last value of the gate used as a clock.
	typedef struct packed {
		logic q;
		logic clk_d;
	} mode_state_t;

	mode_state_t s_r;   // Registered state.
	mode_state_t s_nxt; // Next state.
	logic        rise;  // Rising edge on gate 1.

	////////////////////////////////////////////////////////////////////////
	// Latches and flip-flops are built on hclk; the gate clock is edge
	// detected, so it must be slower than half the system clock.
	always_comb begin
		s_nxt = s_r;
		s_nxt.clk_d = g[0];
		rise = g[0] & ~s_r.clk_d;
		res = 1'b0;
		unique case (mode)
			clc_pkg::MODE_AND_OR: res = (g[0] & g[1]) | (g[2] & g[3]);
			clc_pkg::MODE_OR_XOR: res = (g[0] | g[1]) ^ (g[2] | g[3]);
			clc_pkg::MODE_AND4:   res = &g;
			clc_pkg::MODE_SR: begin
				// Set wins when both are high.
				if (g[0] | g[1]) begin
					s_nxt.q = 1'b1;
				end else if (g[2] | g[3]) begin
					s_nxt.q = 1'b0;
				end
				res = s_nxt.q;
			end
			clc_pkg::MODE_DFF1: begin
				if (g[2]) begin
					s_nxt.q = 1'b0;
				end else if (g[3]) begin
					s_nxt.q = 1'b1;
				end else if (rise) begin
					s_nxt.q = g[1];
				end
				res = s_nxt.q;
			end
			clc_pkg::MODE_DFF2: begin
				if (g[2]) begin
					s_nxt.q = 1'b0;
				end else if (rise) begin
					s_nxt.q = g[1] ^ g[3];
				end
				res = s_nxt.q;
			end
			clc_pkg::MODE_JK: begin
				if (g[2]) begin
					s_nxt.q = 1'b0;
				end else if (rise) begin
					s_nxt.q = (g[1] & ~s_r.q) | (~g[3] & s_r.q);
				end
				res = s_nxt.q;
			end
			clc_pkg::MODE_LATCH: begin
				// Transparent while gate 1 is high.
				if (g[2]) begin
					s_nxt.q = 1'b0;
				end else if (g[3]) begin
					s_nxt.q = 1'b1;
				end else if (g[0]) begin
					s_nxt.q = g[1];
				end
				res = s_nxt.q;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule
`default_nettype wire

// [hw/clc_top.sv]
// Four logic cells with gate selection, output mirror and AHB-Lite registers.
// How it works
// - third gate has 8-bit true/inverted select
// - fourth gate has same 8-bit select layout
// - set select bit feeds that form in
// - gate selects read/write, kept except power-on
// - shared register mirrors cell outputs, resets zero
// - mirror upper bits read zero, ignore writes
// - disabled cell drives zero output
// - three-bit field picks cell function
// - chosen output edges set interrupt flag
// - output bit follows polarity, one inverts
`timescale 1ns/1ns
`default_nettype none
`include "clc_defines.svh"

module clc_top #(
	parameter int NSRC = 64, // Sources reachable by a 6-bit data select.
	parameter int NPIN = 64  // Pins reachable by a 6-bit pin select.
) (
	// Clock and reset.
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// AHB-Lite slave.
	input  wire logic              hsel,
	input  wire logic       [31:0] haddr,
	input  wire logic        [1:0] htrans,
	input  wire logic              hwrite,
	input  wire logic        [2:0] hsize,
	input  wire logic       [31:0] hwdata,
	input  wire logic              hready,
	output logic            [31:0] hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Signal sources above the four external inputs, and the pins.
	input  wire logic   [NSRC-5:0] periph_src,
	input  wire logic   [NPIN-1:0] pins,
	// Cell outputs and interrupt.
	output logic             [3:0] cell_out,
	output logic                   irq
);

	// Whole block state.
	typedef struct packed {
		clc_pkg::cell_cfg_t [3:0] cr;   // Per cell settings.
		logic [3:0][5:0]  psel;         // Pin select of each external input.
		logic [3:0]       flag;         // Sticky interrupt flags.
		logic [3:0]       mask;         // Interrupt mask.
		logic [3:0]       out;          // Cell outputs after polarity.
		logic             irq;          // Interrupt line.
		logic             wr_pend;      // Write data phase pending.
		logic             rd_pend;      // Read data phase pending.
		logic [8:0]       ad;           // Word address of the data phase.
		logic [31:0]      rdata;        // Read data.
	} top_state_t;

	top_state_t s_r;   // Registered state.
	top_state_t s_nxt; // Next state.

	logic [3:0]      ext;       // External inputs after pin select.
	logic [NSRC-1:0] src;       // All data sources.
	logic [3:0][3:0] dat;       // Data inputs of each cell.
	logic [3:0][3:0] gate_w;    // Gate results of each cell.
	logic [3:0]      res;       // Cell results before polarity.
	logic            ap;        // Valid address phase.
	logic [31:0]     rd;        // Read data for the address phase.

	////////////////////////////////////////////////////////////////////////
	// Word offset of an access within the cell or shared window.
	function automatic logic [3:0] reg_idx(input logic [8:0] a);
		return a[3:0];
	endfunction

	// Cell number of an access in the cell windows.
	function automatic logic [1:0] cell_idx(input logic [8:0] a);
		return a[5:4];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input routing: pins to external inputs, sources to cell data.
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			ext[k] = pins[s_r.psel[k]];
		end
		src = {periph_src, ext};
	end

	for (genvar c = 0; c < 4; c++) begin : g_cell
		always_comb begin
			for (int k = 0; k < 4; k++) begin
				dat[c][k] = src[s_r.cr[c].dsel[k]];
			end
		end
		for (genvar j = 0; j < 4; j++) begin : g_gate
			clc_gate u_gate (
				.d   (dat[c]),
				.sel (s_r.cr[c].gsel[j]),
				.inv (s_r.cr[c].gate_invert[j]),
				.g   (gate_w[c][j])
			);
		end
		clc_mode u_mode (
			.hclk    (hclk),
			.hresetn (hresetn),
			.g       (gate_w[c]),
			.mode    (s_r.cr[c].cell_function_select),
			.res     (res[c])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: bus writes, cell outputs, flags, then the read mux.
	// Reads use the next state so a read right after a write sees it.
	always_comb begin
		logic [7:0] wd;
		logic [3:0] ix;
		logic [1:0] ci;
		logic [3:0] clr;
		logic [3:0] set;
		wd = hwdata[7:0];
		ix = reg_idx(s_r.ad);
		ci = cell_idx(s_r.ad);
		clr = 4'h0;
		set = 4'h0;
		s_nxt = s_r;
		ap = hsel & htrans[1] & hready;
		// Write data phase; unmapped words are ignored.
		if (s_r.wr_pend && !s_r.ad[`CLC_GLOBAL_BIT]) begin
			if (ix == `CLC_REG_CON) begin
				s_nxt.cr[ci].cell_enable = wd[`CLC_CON_EN];
				s_nxt.cr[ci].rise_irq_enable = wd[`CLC_CON_INTP];
				s_nxt.cr[ci].fall_irq_enable = wd[`CLC_CON_INTN];
				s_nxt.cr[ci].cell_function_select = clc_pkg::mode_t'(wd[2:0]);
			end else if (ix == `CLC_REG_POL) begin
				s_nxt.cr[ci].output_invert = wd[`CLC_POL_OUT];
				s_nxt.cr[ci].gate_invert = wd[3:0];
			end else if (ix <= `CLC_REG_DSEL3) begin
				s_nxt.cr[ci].dsel[2'(ix - `CLC_REG_DSEL0)] = wd[5:0];
			end else if (ix <= `CLC_REG_GSEL3) begin
				s_nxt.cr[ci].gsel[2'(ix - `CLC_REG_GSEL0)] = wd;
			end
		end else if (s_r.wr_pend) begin
			// The mirror takes no write at all.
			if (ix >= `CLC_REG_PSEL0 && ix <= `CLC_REG_PSEL3) begin
				s_nxt.psel[2'(ix - `CLC_REG_PSEL0)] = wd[5:0];
			end else if (ix == `CLC_REG_STATUS) begin
				clr = wd[3:0];
			end else if (ix == `CLC_REG_MASK) begin
				s_nxt.mask = wd[3:0];
			end
		end
		// Cell outputs and edge events.
		for (int c = 0; c < 4; c++) begin
			if (s_r.cr[c].cell_enable) begin
				s_nxt.out[c] = res[c] ^ s_r.cr[c].output_invert;
			end else begin
				s_nxt.out[c] = 1'b0;
			end
			set[c] = (s_nxt.out[c] & ~s_r.out[c] & s_r.cr[c].rise_irq_enable)
				| (~s_nxt.out[c] & s_r.out[c] & s_r.cr[c].fall_irq_enable);
		end
		// A new event beats a clear in the same cycle.
		s_nxt.flag = (s_r.flag & ~clr) | set;
		s_nxt.irq = |(s_nxt.flag & s_nxt.mask);
		// Address phase.
		s_nxt.wr_pend = ap & hwrite;
		s_nxt.rd_pend = ap & ~hwrite;
		if (ap) begin
			s_nxt.ad = haddr[10:2];
		end
		rd = 32'h0000_0000;
		ix = reg_idx(haddr[10:2]);
		ci = cell_idx(haddr[10:2]);
		// The window bit is a word address bit, two places up in the byte address.
		if (!haddr[`CLC_GLOBAL_BIT + 2]) begin
			if (ix == `CLC_REG_CON) begin
				rd[`CLC_CON_EN] = s_nxt.cr[ci].cell_enable;
				rd[`CLC_CON_OUT] = s_nxt.out[ci];
				rd[`CLC_CON_INTP] = s_nxt.cr[ci].rise_irq_enable;
				rd[`CLC_CON_INTN] = s_nxt.cr[ci].fall_irq_enable;
				rd[2:0] = s_nxt.cr[ci].cell_function_select;
			end else if (ix == `CLC_REG_POL) begin
				rd[`CLC_POL_OUT] = s_nxt.cr[ci].output_invert;
				rd[3:0] = s_nxt.cr[ci].gate_invert;
			end else if (ix <= `CLC_REG_DSEL3) begin
				rd[5:0] = s_nxt.cr[ci].dsel[2'(ix - `CLC_REG_DSEL0)];
			end else if (ix <= `CLC_REG_GSEL3) begin
				rd[7:0] = s_nxt.cr[ci].gsel[2'(ix - `CLC_REG_GSEL0)];
			end
		end else begin
			if (ix == `CLC_REG_MIRROR) begin
				rd[3:0] = s_nxt.out;
			end else if (ix <= `CLC_REG_PSEL3) begin
				rd[5:0] = s_nxt.psel[2'(ix - `CLC_REG_PSEL0)];
			end else if (ix == `CLC_REG_STATUS) begin
				rd[3:0] = s_nxt.flag;
			end else if (ix == `CLC_REG_MASK) begin
				rd[3:0] = s_nxt.mask;
			end
		end
		if (ap && !hwrite) begin
			s_nxt.rdata = rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register. Only the power-on reset exists here, so the gate
	// selects take a defined zero instead of an unknown value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			for (int c = 0; c < 4; c++) begin
				s_r.cr[c].gsel <= {4{`CLC_GSEL_RST}};
			end
			s_r.out <= `CLC_MIRROR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register; zero wait, always OKAY.
	always_comb begin
		hrdata = s_r.rdata;
		hreadyout = 1'b1;
		hresp = 1'b0;
		cell_out = s_r.out;
		irq = s_r.irq;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on cell 0 and the shared registers.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_g3_write: assert property (
		s_r.wr_pend && s_r.ad == 9'h008 |=> s_r.cr[0].gsel[2] == $past(hwdata[7:0])
	) else $error("third gate select not written");

	a_g4_write: assert property (
		s_r.wr_pend && s_r.ad == 9'h009 |=> s_r.cr[0].gsel[3] == $past(hwdata[7:0])
	) else $error("fourth gate select not written");

	a_true_form: assert property (
		s_r.cr[0].gsel[2][1] && dat[0][0] && !s_r.cr[0].gate_invert[2] |-> gate_w[0][2]
	) else $error("selected true form missing from gate");

	a_sel_hold: assert property (
		!(s_r.wr_pend && !s_r.ad[8] && s_r.ad[5:4] == 2'h0) |=> $stable(s_r.cr[0].gsel)
	) else $error("gate select changed without a write");

	a_mirror_live: assert property (
		s_r.rd_pend && s_r.ad == 9'h100 |-> hrdata[3:0] == cell_out
	) else $error("mirror differs from cell outputs");

	a_mirror_high: assert property (
		s_r.rd_pend && s_r.ad == 9'h100 |-> hrdata[31:4] == 28'h0
	) else $error("mirror upper bits not zero");

	a_off_zero: assert property (
		!s_r.cr[0].cell_enable [*2] |-> !cell_out[0]
	) else $error("disabled cell output not zero");

	a_and_mode: assert property (
		s_r.cr[0].cell_enable && !s_r.cr[0].output_invert
		&& s_r.cr[0].cell_function_select == clc_pkg::MODE_AND4
		|=> cell_out[0] == $past(&gate_w[0])
	) else $error("four-input AND result wrong");

	a_rise_flag: assert property (
		s_r.cr[0].rise_irq_enable && $rose(s_nxt.out[0]) |=> s_r.flag[0]
	) else $error("rising edge did not set flag");

	a_fall_flag: assert property (
		s_r.cr[0].fall_irq_enable && $fell(s_nxt.out[0]) |=> s_r.flag[0]
	) else $error("falling edge did not set flag");

	a_polarity: assert property (
		s_r.cr[0].cell_enable |=> cell_out[0] == ($past(res[0]) ^ $past(s_r.cr[0].output_invert))
	) else $error("output polarity not applied");

	a_empty_gate: assert property (
		s_r.cr[0].gsel[0] == 8'h00 |-> gate_w[0][0] == s_r.cr[0].gate_invert[0]
	) else $error("empty gate not zero before polarity");

	a_flag_hold: assert property (
		s_r.flag[0] && !(s_r.wr_pend && s_r.ad == 9'h105 && hwdata[0]) |=> s_r.flag[0]
	) else $error("sticky flag lost without a clear");

	c_irq: cover property (s_r.mask[0] && $rose(irq));
	c_latch: cover property (s_r.cr[0].cell_function_select == clc_pkg::MODE_LATCH
		&& $rose(cell_out[0]));
	c_mirror: cover property (s_r.rd_pend && s_r.ad == 9'h100 && hrdata[0]);
	c_toggle: cover property (s_r.cr[0].cell_function_select == clc_pkg::MODE_JK
		&& $fell(cell_out[0]));

endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench of the four logic cells behind the AHB-Lite register bus.
`timescale 1ns/1ns
`default_nettype none

module testbench;
	// Byte addresses of the shared registers and of one unmapped word.
	localparam logic [31:0] A_MIRROR = 32'h0000_0400;
	localparam logic [31:0] A_STATUS = 32'h0000_0414;
	localparam logic [31:0] A_MASK   = 32'h0000_0418;
	localparam logic [31:0] A_HOLE   = 32'h0000_041C;

	logic        hclk;       // System clock.
	logic        hresetn;    // Reset, active low.
	logic        hsel;       // Bus select.
	logic [31:0] haddr;      // Bus address.
	logic [1:0]  htrans;     // Transfer kind.
	logic        hwrite;     // Write when high.
	logic [2:0]  hsize;      // Transfer size.
	logic [31:0] hwdata;     // Write data.
	logic        hready;     // Bus ready, the one slave's own.
	logic [31:0] hrdata;     // Read data.
	logic        hreadyout;  // Slave ready.
	logic        hresp;      // Slave response.
	logic [59:0] periph_src; // Sources 4 to 63.
	logic [63:0] pins;       // Pin levels.
	logic [3:0]  cell_out;   // Cell outputs.
	logic        irq;        // Interrupt.
	int          n_mismatch; // Mismatches seen.
	int          n_tests;    // Comparisons made.

	assign hready = hreadyout;

	clc_top #(.NSRC(64), .NPIN(64)) clc_top_i (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (hsize),
		.hwdata     (hwdata),
		.hready     (hready),
		.hrdata     (hrdata),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.periph_src (periph_src),
		.pins       (pins),
		.cell_out   (cell_out),
		.irq        (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz.
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Waits for ready under a bound, so a stuck slave is counted after 50 cycles.
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check("hready", {31'h0, hready}, 32'h0000_0001);
		end
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic reg_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		check(name, rd, exp);
	endtask

	// Cell outputs are registered, so a few edges are let pass after any change.
	task automatic settle();
		repeat (3) @(posedge hclk);
	endtask

	task automatic drive(input logic [3:0] v);
		periph_src <= {56'h0, v};
		settle();
	endtask

	// Gate 1 low, then high again: one rising edge of the cell's gate clock.
	task automatic pulse_clock();
		reg_wr(32'h0000_0004, 32'h0000_000A);
		reg_wr(32'h0000_0004, 32'h0000_000B);
		settle();
	endtask

	// Reference gate: OR of the picked true and inverted forms.
	function automatic logic gate_exp(input logic [3:0] d, input logic [7:0] s);
		logic acc;
		acc = 1'b0;
		for (int k = 0; k < 4; k++) begin
			acc = acc | (s[2*k+1] & d[k]) | (s[2*k] & ~d[k]);
		end
		return acc;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset();
		for (int j = 0; j < 4; j++) begin
			reg_chk("gate_select_reset", 32'(24 + 4*j), 32'h0);
		end
		reg_chk("mirror_reset", A_MIRROR, 32'h0);
		check("cell_out_reset", {28'h0, cell_out}, 32'h0);
		reg_wr(32'h0000_0020, 32'hFFFF_FF5A);
		reg_chk("gate_select_upper", 32'h0000_0020, 32'h0000_005A);
		reg_wr(A_HOLE, 32'hFFFF_FFFF);
		reg_chk("unmapped", A_HOLE, 32'h0);
		reg_wr(32'h0000_0404, 32'hFFFF_FFE5);
		reg_chk("pin_select", 32'h0000_0404, 32'h0000_0025);
	endtask

	// Gates 3 and 4 alone steer a four-input AND; the other gates are forced high.
	task automatic t_gates();
		logic [7:0]  s;
		logic [31:0] a;
		reg_wr(32'h0000_0000, 32'h0000_0082);
		for (int k = 0; k < 4; k++) begin
			reg_wr(32'(8 + 4*k), 32'(4 + k));
		end
		for (int j = 2; j < 4; j++) begin
			a = 32'(24 + 4*j);
			reg_wr(32'h0000_0004, 32'(4'hF & ~(4'h1 << j)));
			for (int i = 0; i < 11; i++) begin
				s = (i < 8) ? 8'(1 << i) : (i == 8) ? 8'h00 : (i == 9) ? 8'hFF : 8'h82;
				reg_wr(a, {24'h0, s});
				reg_chk("gate_select", a, {24'h0, s});
				for (int d = 0; d < 16; d++) begin
					drive(4'(d));
					check("gate_result", 32'(cell_out[0]), 32'(gate_exp(4'(d), s)));
				end
			end
			reg_wr(a, 32'h0);
		end
	endtask

	// Gates 1, 2 and 4 high and gate 3 low, so every function below settles to one value.
	task automatic t_modes();
		logic [2:0] mode_tab [6];
		logic       exp_tab  [6];
		mode_tab = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		exp_tab  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		reg_wr(32'h0000_0004, 32'h0000_000B);
		for (int i = 0; i < 6; i++) begin
			reg_wr(32'h0000_0000, {24'h0, 5'h10, mode_tab[i]});
			settle();
			check("mode_result", 32'(cell_out[0]), 32'(exp_tab[i]));
		end
		// The latch left a one; the two-input flip-flop loads gate 2 xor gate 4.
		reg_wr(32'h0000_0000, 32'h0000_0085);
		pulse_clock();
		check("dff2_result", 32'(cell_out[0]), 32'h0);
		// J and K both high: every rising gate clock edge toggles the cell.
		reg_wr(32'h0000_0000, 32'h0000_0086);
		for (int p = 0; p < 3; p++) begin
			pulse_clock();
			check("jk_toggle", 32'(cell_out[0]), {31'h0, !p[0]});
		end
		reg_chk("mirror_cell1", A_MIRROR, 32'h0000_0001);
		reg_wr(32'h0000_0004, 32'h0000_008B);
		settle();
		check("inverted_out", 32'(cell_out[0]), 32'h0);
		reg_chk("mirror_inverted", A_MIRROR, 32'h0);
		reg_wr(32'h0000_0000, 32'h0000_0007);
		settle();
		check("disabled_out", 32'(cell_out[0]), 32'h0);
		reg_wr(32'h0000_0004, 32'h0000_000F);
		settle();
		check("disabled_out", 32'(cell_out[0]), 32'h0);
	endtask

	// Cell 4 lands in bit 3; writes to the mirror change nothing.
	task automatic t_mirror();
		reg_wr(32'h0000_00C4, 32'h0000_000F);
		reg_wr(32'h0000_00C0, 32'h0000_0082);
		settle();
		check("cell4_out", {28'h0, cell_out}, 32'h0000_0008);
		reg_wr(A_MIRROR, 32'hFFFF_FFFF);
		reg_chk("mirror_cell4", A_MIRROR, 32'h0000_0008);
		reg_wr(32'h0000_00C0, 32'h0000_0000);
		settle();
		reg_chk("mirror_off", A_MIRROR, 32'h0);
	endtask

	// Cell 1 output follows source 4 through gate 3; edges raise the sticky flag.
	task automatic t_irq();
		drive(4'h0);
		reg_wr(32'h0000_0004, 32'h0000_000B);
		reg_wr(32'h0000_0020, 32'h0000_0002);
		reg_wr(32'h0000_0000, 32'h0000_0092);
		reg_wr(A_MASK, 32'h0000_0001);
		reg_wr(A_STATUS, 32'h0000_000F);
		reg_chk("status_clear", A_STATUS, 32'h0);
		drive(4'h1);
		reg_chk("status_rise", A_STATUS, 32'h0000_0001);
		check("irq_rise", {31'h0, irq}, 32'h0000_0001);
		reg_wr(A_STATUS, 32'h0000_0001);
		reg_chk("status_w1c", A_STATUS, 32'h0);
		check("irq_cleared", {31'h0, irq}, 32'h0);
		drive(4'h0);
		reg_chk("status_no_fall", A_STATUS, 32'h0);
		reg_wr(32'h0000_0000, 32'h0000_008A);
		drive(4'h1);
		reg_chk("status_no_rise", A_STATUS, 32'h0);
		drive(4'h0);
		reg_chk("status_fall", A_STATUS, 32'h0000_0001);
		check("irq_fall", {31'h0, irq}, 32'h0000_0001);
		reg_wr(A_MASK, 32'h0);
		settle();
		check("irq_masked", {31'h0, irq}, 32'h0);
		reg_chk("status_kept", A_STATUS, 32'h0000_0001);
	endtask

	// Reset in mid-run with cell 1 high: outputs, flags and mirror return to zero.
	task automatic t_midreset();
		drive(4'h1);
		check("cell1_high", {28'h0, cell_out}, 32'h0000_0001);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		check("cell_out_midreset", {28'h0, cell_out}, 32'h0);
		check("irq_midreset", {31'h0, irq}, 32'h0);
		reg_chk("mirror_midreset", A_MIRROR, 32'h0);
		reg_chk("status_midreset", A_STATUS, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for five cycles, then every scenario in turn.
	initial begin
		n_mismatch = 0;
		n_tests    = 0;
		hresetn    = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0;
		periph_src = 60'h0;
		pins       = 64'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_gates();
		t_modes();
		t_mirror();
		t_irq();
		t_midreset();
		print_verdict();
	end

	// Watchdog: the run needs well under 10,000 cycles, so 50,000 means a hang.
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict();
	end
endmodule

`default_nettype wire
